// ==== hdl/swc_pkg.sv ====
// Shared constants and types for the standby wake source configuration block.
// Assumes a single 250 MHz clock domain and an AXI4-Lite register master.
package swc_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Register map, byte addresses on a 32-bit AXI4-Lite bus.
  localparam int unsigned    AXI_ADDR_W   = 8;
  localparam logic [7:0]     OFF_CTRL     = 8'h00;
  localparam logic [7:0]     OFF_IRQ_STAT = 8'h04;
  localparam logic [7:0]     OFF_IRQ_MASK = 8'h08;
  localparam logic [1:0]     IDX_CTRL     = 2'h0;
  localparam logic [1:0]     IDX_STAT     = 2'h1;
  localparam logic [1:0]     IDX_MASK     = 2'h2;
  localparam logic [1:0]     IDX_NONE     = 2'h3;
  localparam logic [1:0]     RESP_OKAY    = 2'h0;
  localparam logic [1:0]     RESP_SLVERR  = 2'h2;

  ////////////////////////////////////////////////////////////////////////////
  // Source slots: each source owns one byte lane of the control word.
  localparam int unsigned    NUM_SRC      = 2;
  localparam int unsigned    SRC_CEC      = 0;
  localparam int unsigned    SRC_RMC      = 1;
  localparam int unsigned    SRC_LANE0    = 2;
  localparam int unsigned    EN_POS       = 0;
  localparam int unsigned    ST_POS       = 2;
  localparam int unsigned    CFG_POS      = 4;

  // Active-state configuration codes.
  localparam logic [2:0]     CFG_LOW      = 3'h0;
  localparam logic [2:0]     CFG_HIGH     = 3'h1;
  localparam logic [2:0]     CFG_FALL     = 3'h2;
  localparam logic [2:0]     CFG_RISE     = 3'h3;
  localparam logic [2:0]     CFG_BOTH     = 3'h4;
  localparam logic [2:0]     CFG_RESET    = 3'h2;

  // Reported active-state codes.
  localparam logic [1:0]     ST_NONE      = 2'h0;
  localparam logic [1:0]     ST_RISE      = 2'h1;
  localparam logic [1:0]     ST_FALL      = 2'h2;
  localparam logic [1:0]     ST_BOTH      = 2'h3;

  // One source's software settings travel together.
  typedef struct packed {
    logic [2:0] cfg;
    logic       en;
  } swc_src_t;

  // Maps a configuration code onto the reported edge condition.
  function automatic logic [1:0] swc_cfg_to_state(input logic [2:0] cfg);
    case (cfg)
      CFG_RISE: swc_cfg_to_state = ST_RISE;
      CFG_FALL: swc_cfg_to_state = ST_FALL;
      CFG_BOTH: swc_cfg_to_state = ST_BOTH;
      default:  swc_cfg_to_state = ST_NONE;
    endcase
  endfunction

  // Word decode shared by the read and write paths.
  function automatic logic [1:0] swc_decode(input logic [AXI_ADDR_W-1:0] addr);
    if (addr[AXI_ADDR_W-1:2] == OFF_CTRL[AXI_ADDR_W-1:2]) begin
      swc_decode = IDX_CTRL;
    end else if (addr[AXI_ADDR_W-1:2] == OFF_IRQ_STAT[AXI_ADDR_W-1:2]) begin
      swc_decode = IDX_STAT;
    end else if (addr[AXI_ADDR_W-1:2] == OFF_IRQ_MASK[AXI_ADDR_W-1:2]) begin
      swc_decode = IDX_MASK;
    end else begin
      swc_decode = IDX_NONE;
    end
  endfunction

endpackage

// ==== hdl/swc_wake_det.sv ====
// Per-source wake detector: synchronises the source pin, watches for the
// configured active condition and reports the condition in force.
// Assumes the pin is asynchronous to clk and settings come from clk logic.
`timescale 1ns/100ps
`default_nettype none

module swc_wake_det import swc_pkg::*; (
  input  wire logic       clk,        // System clock.
  input  wire logic       rst,        // Asynchronous reset, active high.
  input  wire logic       pin_async,  // Raw interrupt request from the source.
  input  wire swc_src_t   src,        // Enable and configuration of this source.
  output logic [1:0]      state,      // Reported active condition.
  output logic            hit         // High while the condition releases standby.
);

  logic       sync1_q;
  logic       sync2_q;
  logic       prev_q;
  logic [1:0] state_q;
  logic       hit_q;
  logic       match;

  ////////////////////////////////////////////////////////////////////////////
  // Two-flop synchroniser plus a history flop; only sync2_q and prev_q feed the decode.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sync1_q <= 1'b0;
      sync2_q <= 1'b0;
      prev_q  <= 1'b0;
    end else begin
      sync1_q <= pin_async;
      sync2_q <= sync1_q;
      prev_q  <= sync2_q;
    end
  end

  // Condition decode; level codes act while the level holds.
  always_comb begin
    case (src.cfg)
      CFG_LOW:  match = ~sync2_q;
      CFG_HIGH: match = sync2_q;
      CFG_FALL: match = prev_q & ~sync2_q;
      CFG_RISE: match = sync2_q & ~prev_q;
      CFG_BOTH: match = sync2_q ^ prev_q;
      default:  match = 1'b0;
    endcase
  end

  // Status shows the condition only while the source is enabled, so it is
  // zero out of reset even though the configuration is not.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_q <= ST_NONE;
    end else begin
      state_q <= src.en ? swc_cfg_to_state(src.cfg) : ST_NONE;
    end
  end

  // A disabled source can never release standby.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      hit_q <= 1'b0;
    end else begin
      hit_q <= src.en & match;
    end
  end

  assign state = state_q;
  assign hit   = hit_q;

endmodule

`default_nettype wire

// ==== hdl/swc_top.sv ====
// Standby wake source configuration: control word, edge and level wake detectors for two
// interrupt sources, sticky wake events with mask, and an AXI4-Lite slave.
// Assumes one clock, an AXI4-Lite master with one write and one read in flight.
`timescale 1ns/100ps
`default_nettype none

module swc_top import swc_pkg::*; (
  input  wire logic                  clk,                  // System clock, 250 MHz.
  input  wire logic                  rst,                  // Asynchronous reset, active high.
  input  wire logic                  consumer_ctrl_rx_irq, // Consumer-control receive request.
  input  wire logic                  remote_ctrl_rx_irq,   // Remote-control receive request.
  input  wire logic [AXI_ADDR_W-1:0] awaddr,               // Write address.
  input  wire logic                  awvalid,              // Write address valid.
  output logic                       awready,              // Write address ready.
  input  wire logic [31:0]           wdata,                // Write data.
  input  wire logic [3:0]            wstrb,                // Write byte strobes.
  input  wire logic                  wvalid,               // Write data valid.
  output logic                       wready,               // Write data ready.
  output logic [1:0]                 bresp,                // Write response.
  output logic                       bvalid,               // Write response valid.
  input  wire logic                  bready,               // Write response ready.
  input  wire logic [AXI_ADDR_W-1:0] araddr,               // Read address.
  input  wire logic                  arvalid,              // Read address valid.
  output logic                       arready,              // Read address ready.
  output logic [31:0]                rdata,                // Read data.
  output logic [1:0]                 rresp,                // Read response.
  output logic                       rvalid,               // Read data valid.
  input  wire logic                  rready,               // Read data ready.
  output logic                       standby_release,      // Wake request to the standby logic.
  output logic                       irq                   // Level interrupt on unmasked events.
);

  swc_src_t              src_q [NUM_SRC];
  logic [1:0]            state [NUM_SRC];
  logic [NUM_SRC-1:0]    hit;
  logic [NUM_SRC-1:0]    stat_q;
  logic [NUM_SRC-1:0]    mask_q;
  logic                  irq_q;
  logic                  release_q;
  logic                  awready_q;
  logic                  wready_q;
  logic                  aw_full_q;
  logic                  w_full_q;
  logic [AXI_ADDR_W-1:0] awaddr_q;
  logic [31:0]           wdata_q;
  logic [3:0]            wstrb_q;
  logic                  bvalid_q;
  logic [1:0]            bresp_q;
  logic                  arready_q;
  logic                  rvalid_q;
  logic [31:0]           rdata_q;
  logic [1:0]            rresp_q;
  logic                  do_wr;
  logic [1:0]            widx;
  logic [31:0]           ctrl_rd;
  logic [NUM_SRC-1:0]    stat_clr;

  ////////////////////////////////////////////////////////////////////////////
  // Wake detectors, one per source.
  swc_wake_det u_det_cec (
    .clk       (clk),
    .rst       (rst),
    .pin_async (consumer_ctrl_rx_irq),
    .src       (src_q[SRC_CEC]),
    .state     (state[SRC_CEC]),
    .hit       (hit[SRC_CEC])
  );

  swc_wake_det u_det_rmc (
    .clk       (clk),
    .rst       (rst),
    .pin_async (remote_ctrl_rx_irq),
    .src       (src_q[SRC_RMC]),
    .state     (state[SRC_RMC]),
    .hit       (hit[SRC_RMC])
  );

  ////////////////////////////////////////////////////////////////////////////
  // Write address channel: hold one address until the response is taken.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      awready_q <= 1'b0;
      aw_full_q <= 1'b0;
      awaddr_q  <= '0;
    end else if (awvalid && awready_q) begin
      awready_q <= 1'b0;
      aw_full_q <= 1'b1;
      awaddr_q  <= awaddr;
    end else if (do_wr) begin
      aw_full_q <= 1'b0;
    end else if (!aw_full_q && !bvalid_q) begin
      awready_q <= 1'b1;
    end
  end

  // Write data channel, taken independently of the address.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wready_q <= 1'b0;
      w_full_q <= 1'b0;
      wdata_q  <= '0;
      wstrb_q  <= '0;
    end else if (wvalid && wready_q) begin
      wready_q <= 1'b0;
      w_full_q <= 1'b1;
      wdata_q  <= wdata;
      wstrb_q  <= wstrb;
    end else if (do_wr) begin
      w_full_q <= 1'b0;
    end else if (!w_full_q && !bvalid_q) begin
      wready_q <= 1'b1;
    end
  end

  // A write happens once both halves are held and no response is pending.
  assign do_wr = aw_full_q && w_full_q && !bvalid_q;
  assign widx  = swc_decode(awaddr_q);

  // Write response; unmapped words answer SLVERR and change nothing.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      bvalid_q <= 1'b0;
      bresp_q  <= RESP_OKAY;
    end else if (do_wr) begin
      bvalid_q <= 1'b1;
      bresp_q  <= (widx == IDX_NONE) ? RESP_SLVERR : RESP_OKAY;
    end else if (bready) begin
      bvalid_q <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Source settings. Each source lives in its own byte lane, so a byte
  // strobe touches at most one source. Status bits are not stored here and
  // so cannot be written; gaps between fields have no storage at all.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < NUM_SRC; i++) begin
        src_q[i].en  <= 1'b0;
        src_q[i].cfg <= CFG_RESET;
      end
    end else if (do_wr && widx == IDX_CTRL) begin
      for (int i = 0; i < NUM_SRC; i++) begin
        if (wstrb_q[SRC_LANE0+i]) begin
          src_q[i].en  <= wdata_q[8*(SRC_LANE0+i)+EN_POS];
          src_q[i].cfg <= wdata_q[8*(SRC_LANE0+i)+CFG_POS +: 3];
        end
      end
    end
  end

  // Control word image; every bit not driven here reads as zero.
  always_comb begin
    ctrl_rd = '0;
    for (int i = 0; i < NUM_SRC; i++) begin
      ctrl_rd[8*(SRC_LANE0+i)+EN_POS]      = src_q[i].en;
      ctrl_rd[8*(SRC_LANE0+i)+ST_POS +: 2] = state[i];
      ctrl_rd[8*(SRC_LANE0+i)+CFG_POS +: 3] = src_q[i].cfg;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Wake events: sticky, cleared by writing one, and a new event in the
  // clearing cycle survives because the set term is OR-ed in last.
  assign stat_clr = (do_wr && widx == IDX_STAT && wstrb_q[0]) ?
                    wdata_q[NUM_SRC-1:0] : '0;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      stat_q <= '0;
    end else begin
      stat_q <= (stat_q & ~stat_clr) | hit;
    end
  end

  // Interrupt mask, one bit per event.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      mask_q <= '0;
    end else if (do_wr && widx == IDX_MASK && wstrb_q[0]) begin
      mask_q <= wdata_q[NUM_SRC-1:0];
    end
  end

  // Registered outputs: the interrupt follows the sticky bits, the wake
  // request follows the live detector output so standby sees no backlog.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      irq_q     <= 1'b0;
      release_q <= 1'b0;
    end else begin
      irq_q     <= |(stat_q & mask_q);
      release_q <= |hit;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read channel: data is captured at the address handshake.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      arready_q <= 1'b0;
      rvalid_q  <= 1'b0;
      rdata_q   <= '0;
      rresp_q   <= RESP_OKAY;
    end else if (arvalid && arready_q) begin
      arready_q <= 1'b0;
      rvalid_q  <= 1'b1;
      rresp_q   <= RESP_OKAY;
      unique case (swc_decode(araddr))
        IDX_CTRL: rdata_q <= ctrl_rd;
        IDX_STAT: rdata_q <= {{(32-NUM_SRC){1'b0}}, stat_q};
        IDX_MASK: rdata_q <= {{(32-NUM_SRC){1'b0}}, mask_q};
        IDX_NONE: begin
          rdata_q <= '0;
          rresp_q <= RESP_SLVERR;
        end
      endcase
    end else if (rvalid_q && rready) begin
      rvalid_q  <= 1'b0;
      arready_q <= 1'b1;
    end else if (!rvalid_q) begin
      arready_q <= 1'b1;
    end
  end

  assign awready         = awready_q;
  assign wready          = wready_q;
  assign bvalid          = bvalid_q;
  assign bresp           = bresp_q;
  assign arready         = arready_q;
  assign rvalid          = rvalid_q;
  assign rdata           = rdata_q;
  assign rresp           = rresp_q;
  assign irq             = irq_q;
  assign standby_release = release_q;

  ////////////////////////////////////////////////////////////////////////////
  // Checks on the block's own behaviour.
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  sequence s_ctrl_read;
    arvalid && arready_q && swc_decode(araddr) == IDX_CTRL;
  endsequence

  sequence s_ctrl_write_rmc;
    do_wr && widx == IDX_CTRL && wstrb_q[SRC_LANE0+SRC_RMC];
  endsequence

  AST_CEC_DISABLED_NO_WAKE: assert property (
    !src_q[SRC_CEC].en |=> !hit[SRC_CEC] ##1 (release_q == $past(hit[SRC_RMC])))
    else $error("disabled consumer-control source released standby");

  AST_RMC_EN_AT_BIT24: assert property (
    s_ctrl_read |=> rdata_q[24] == $past(src_q[SRC_RMC].en))
    else $error("remote-control enable not at bit 24");

  AST_STATE_RISE_CODE: assert property (
    (src_q[SRC_CEC].en && src_q[SRC_CEC].cfg == CFG_RISE) [*2] |-> state[SRC_CEC] == 2'h1)
    else $error("rising-edge status code is not 01");

  AST_RMC_STATE_AT_27_26: assert property (
    s_ctrl_read |=> rdata_q[27:26] == $past(state[SRC_RMC]))
    else $error("remote-control status not at bits 27:26");

  AST_RMC_CFG_WRITE: assert property (
    s_ctrl_write_rmc |=> src_q[SRC_RMC].cfg == $past(wdata_q[30:28]))
    else $error("remote-control configuration not written from bits 30:28");

  AST_GAPS_READ_ZERO: assert property (
    s_ctrl_read |=> rdata_q[15:0] == 16'h0000 && !rdata_q[17] && !rdata_q[23]
                    && !rdata_q[25] && !rdata_q[31])
    else $error("unused control bit read as one");

  AST_EVENT_STICKY: assert property (
    hit[SRC_RMC] |=> stat_q[SRC_RMC] ##1 (irq_q || !$past(mask_q[SRC_RMC])))
    else $error("wake event did not set sticky status");

  AST_WRITE_RESPONSE: assert property (
    aw_full_q && w_full_q && !bvalid_q |=> bvalid_q && !aw_full_q && !w_full_q)
    else $error("write response not one cycle after write");

  // The consumer-control enable must read back from its own bit.
  AST_CEC_EN_AT_BIT16: assert property (
    s_ctrl_read |=> rdata_q[16] == $past(src_q[SRC_CEC].en))
    else $error("consumer-control enable not at bit 16");

  // A disabled source reports no condition, which also keeps reset at zero.
  AST_RMC_STATE_OFF_DISABLED: assert property (
    !src_q[SRC_RMC].en |=> state[SRC_RMC] == ST_NONE)
    else $error("disabled remote-control source reports a condition");

  // Writing one clears an event when no new event arrives in that cycle.
  AST_STAT_WRITE_ONE_CLEARS: assert property (
    do_wr && widx == IDX_STAT && wstrb_q[0] && wdata_q[SRC_RMC] && !hit[SRC_RMC]
    |=> !stat_q[SRC_RMC])
    else $error("writing one did not clear the wake event");

endmodule

`default_nettype wire

// ==== dv/test_standby_wake_source_config.sv ====
// Self-checking bench for the standby wake source block, reached over AXI4-Lite.
// Assumes swc_pkg and swc_top are compiled first; the bench drives every port itself.
`timescale 1ns/100ps
`default_nettype none

module test_standby_wake_source_config;
  import swc_pkg::*;

  logic        clk;
  logic        rst;
  logic        consumer_ctrl_rx_irq;
  logic        remote_ctrl_rx_irq;
  logic [7:0]  awaddr;
  logic [7:0]  araddr;
  logic [31:0] wdata;
  logic [31:0] rdata;
  logic [3:0]  wstrb;
  logic        awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready;
  logic [1:0]  bresp;
  logic [1:0]  rresp;
  logic        standby_release;
  logic        irq;
  int          err_total;
  int          compares;
  int          cnt;
  logic [31:0] rd;
  logic [1:0]  rsp;
  // Configuration codes walked through, and the status each must report once enabled.
  logic [2:0]  cfg_tab [6] = '{3'h2, 3'h4, 3'h0, 3'h1, 3'h5, 3'h3};
  logic [1:0]  st_tab [6]  = '{2'h2, 2'h3, 2'h0, 2'h0, 2'h0, 2'h1};

  swc_top dut (
    .clk(clk), .rst(rst),
    .consumer_ctrl_rx_irq(consumer_ctrl_rx_irq), .remote_ctrl_rx_irq(remote_ctrl_rx_irq),
    .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arvalid(arvalid), .arready(arready),
    .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .standby_release(standby_release), .irq(irq)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Free-running 250 MHz clock.
  always #2 clk = ~clk;

  // Compares one value and counts it; reports a difference at once.
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      err_total++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // One write; each task starts a cycle late so a release never meets a new request.
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    forever begin
      @(posedge clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid) break;
    end
    rsp = bresp;
    bready <= 1'b0;
  endtask

  // One read; data and response are taken at the edge where rvalid is seen.
  task automatic axi_rd(input logic [7:0] a);
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    forever begin
      @(posedge clk);
      if (arready) arvalid <= 1'b0;
      if (rvalid) break;
    end
    rd = rdata;
    rsp = rresp;
    rready <= 1'b0;
  endtask

  // One source's byte lane of the control word.
  function automatic logic [7:0] lane(input logic [2:0] c, input logic e, input logic [1:0] st);
    return {1'b0, c, st, 1'b0, e};
  endfunction

  // Counts cycles with the wake request high over a window.
  task automatic count_rel(input int n);
    cnt = 0;
    repeat (n) begin
      @(posedge clk);
      if (standby_release === 1'b1) cnt++;
    end
  endtask

  task automatic print_verdict();
    $display("counts: compares %0d mismatches %0d", compares, err_total);
    if (err_total == 0 && compares > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Watchdog: the whole sequence needs well under two thousand cycles.
  initial begin
    #100000;
    err_total++;
    print_verdict();
  end

  // Main sequence of tests.
  initial begin
    clk = 1'b0;
    rst = 1'b1;
    err_total = 0;
    compares = 0;
    {consumer_ctrl_rx_irq, remote_ctrl_rx_irq} = 2'b00;
    {awaddr, araddr, wdata, wstrb} = '0;
    {awvalid, wvalid, bready, arvalid, rready} = 5'b00000;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    axi_rd(OFF_CTRL);
    check("ctrl reset", rd, 32'h2020_0000);
    axi_rd(OFF_IRQ_STAT);
    check("stat reset", rd, 32'h0000_0000);
    axi_rd(OFF_IRQ_MASK);
    check("mask reset", rd, 32'h0000_0000);
    $display("test reset done");

    // Spare and read-only bits written high must not stick.
    axi_wr(OFF_CTRL, 32'hBEBE_0000, 4'hC);
    check("ctrl wr resp", {30'h0, rsp}, {30'h0, RESP_OKAY});
    axi_rd(OFF_CTRL);
    check("ctrl spare", rd, 32'h3030_0000);
    axi_wr(OFF_CTRL, 32'h3131_0000, 4'hC);
    axi_rd(OFF_CTRL);
    check("ctrl enabled", rd, 32'h3535_0000);
    $display("test fields done");

    // Each code in cfg_tab: configure with enable low, then enable in a separate write.
    for (int i = 0; i < 6; i++) begin
      // Drop the enables first so no write changes a setting and its enable together.
      axi_wr(OFF_CTRL, rd & 32'hFEFE_FFFF, 4'hC);
      axi_wr(OFF_CTRL, {lane(cfg_tab[i], 1'b0, 2'h0), lane(cfg_tab[i], 1'b0, 2'h0), 16'h0}, 4'hC);
      axi_rd(OFF_CTRL);
      check("cfg off", rd, {lane(cfg_tab[i], 1'b0, 2'h0), lane(cfg_tab[i], 1'b0, 2'h0), 16'h0});
      axi_wr(OFF_CTRL, {lane(cfg_tab[i], 1'b1, 2'h0), lane(cfg_tab[i], 1'b1, 2'h0), 16'h0}, 4'hC);
      axi_rd(OFF_CTRL);
      check("cfg on", rd, {lane(cfg_tab[i], 1'b1, st_tab[i]), lane(cfg_tab[i], 1'b1, st_tab[i]),
            16'h0});
    end
    // The low-level code matched the idle pins while enabled; clear those events.
    axi_rd(OFF_IRQ_STAT);
    check("level stat", rd, 32'h0000_0003);
    axi_wr(OFF_IRQ_STAT, 32'h0000_0003, 4'h1);
    $display("test codes done");

    // Rising edge on both slots, only the remote-control slot enabled.
    axi_wr(OFF_CTRL, {lane(3'h3, 1'b0, 2'h0), lane(3'h3, 1'b0, 2'h0), 16'h0}, 4'hC);
    axi_wr(OFF_CTRL, {lane(3'h3, 1'b1, 2'h0), lane(3'h3, 1'b0, 2'h0), 16'h0}, 4'hC);
    remote_ctrl_rx_irq <= 1'b1;
    count_rel(12);
    check("remote rise pulses", cnt, 32'd1);
    consumer_ctrl_rx_irq <= 1'b1;
    count_rel(12);
    check("disabled source pulses", cnt, 32'd0);
    remote_ctrl_rx_irq <= 1'b0;
    count_rel(12);
    check("remote fall pulses", cnt, 32'd0);
    axi_rd(OFF_IRQ_STAT);
    check("irq status", rd, 32'h0000_0002);
    check("irq masked", {31'h0, irq}, 32'h0);
    $display("test wake done");

    // Unmask, then clear by writing ones.
    axi_wr(OFF_IRQ_MASK, 32'h0000_0002, 4'h1);
    repeat (3) @(posedge clk);
    check("irq unmasked", {31'h0, irq}, 32'h1);
    axi_wr(OFF_IRQ_STAT, 32'h0000_0003, 4'h1);
    repeat (3) @(posedge clk);
    axi_rd(OFF_IRQ_STAT);
    check("irq cleared", rd, 32'h0000_0000);
    check("irq low", {31'h0, irq}, 32'h0);
    $display("test interrupt done");

    // Unmapped word: error response, reads zero, control word untouched.
    axi_wr(8'h0C, 32'hFFFF_FFFF, 4'hF);
    check("unmapped wr resp", {30'h0, rsp}, {30'h0, RESP_SLVERR});
    axi_rd(8'h0C);
    check("unmapped rd resp", {30'h0, rsp}, {30'h0, RESP_SLVERR});
    check("unmapped rd data", rd, 32'h0000_0000);
    axi_rd(OFF_CTRL);
    check("ctrl kept", rd, 32'h3530_0000);
    $display("test unmapped done");
    print_verdict();
  end

endmodule
`default_nettype wire
